// ===== hdl/dtec_tick.sv
// Count clock generator: prescaled core clock or selected edge of the event pin
`default_nettype none

module dtec_tick
   import dtec_pkg::*;
#(
   parameter int PRE_W = 9
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] sel,
   input wire logic run,
   input wire logic event_in,
   output logic tick
);

   // ==========================================================
   // Prescaler and edge detect
   logic [PRE_W-1:0] pre_q;
   logic ev_prev_q;
   logic tick_q;
   logic [8:0] mask;
   logic ev_rise;
   logic ev_fall;
   logic pre_hit;
   logic tick_d;

   assign mask = (sel == DTEC_CSEL_DIV4)   ? DTEC_MASK_DIV4 :
                 (sel == DTEC_CSEL_DIV8)   ? DTEC_MASK_DIV8 :
                 (sel == DTEC_CSEL_DIV16)  ? DTEC_MASK_DIV16 :
                 (sel == DTEC_CSEL_DIV32)  ? DTEC_MASK_DIV32 :
                 (sel == DTEC_CSEL_DIV128) ? DTEC_MASK_DIV128 : DTEC_MASK_DIV512;
   assign ev_rise = event_in && !ev_prev_q;
   assign ev_fall = !event_in && ev_prev_q;
   assign pre_hit = ((pre_q & PRE_W'(mask)) == PRE_W'(mask));
   // Prescaler restarts with the run bit, so the first tick comes a full period after run is set
   assign tick_d = run && ((sel == DTEC_CSEL_FALL) ? ev_fall :
                           (sel == DTEC_CSEL_RISE) ? ev_rise : pre_hit);
   assign tick = tick_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pre_q <= '0;
         ev_prev_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         pre_q <= run ? PRE_W'(pre_q + 1'b1) : '0;
         ev_prev_q <= event_in;
         tick_q <= tick_d;
      end
   end

endmodule : dtec_tick

`default_nettype wire

// ===== hdl/dtec_top.sv
// Dual 8-bit timer/event counter with 16-bit cascade, register port and outputs
// ==========================================================
// Operation
// RULE_01 - Software selects 00H for falling or 01H for rising event edges.
// RULE_02 - Event mode: counter increments on each selected valid pin edge while running.
// RULE_03 - Clear-and-start: on match, pulse interrupt and clear count to 00H.
// RULE_04 - Event counting with compare N interrupts after N plus one edges.
// RULE_05 - Square wave: each match toggles output flip-flop when inversion enabled.
// RULE_06 - Software loads 00001011B or 00000111B for square-wave output.
// RULE_07 - PWM bit makes counter free-run; polarity picks active level, enable gates.
// RULE_08 - PWM output stays inactive after start until first overflow.
// RULE_09 - PWM: overflow drives active, match drives inactive, repeating.
// RULE_10 - Clearing run in PWM stops counting and forces output inactive.
// RULE_11 - PWM period 256 count clocks, active width N clocks.
// RULE_12 - Compare written before FFH count edge applies at next overflow.
// RULE_13 - Compare written after FFH count edge applies at second overflow.
// RULE_14 - Compare read returns newly written value while old one still governs.
// RULE_15 - Software spaces PWM compare writes three count clocks apart.
// RULE_16 - Upper cascade bit chains counters into 16 bits on lower clock select.
// RULE_17 - Cascade compare: lower compare is low byte, upper compare high byte.
// RULE_18 - Cascade match pulses lower interrupt and clears 16-bit count to 0000H.
// RULE_19 - Cascade event mode counts valid edges at lower event input.
// RULE_20 - Software starts upper run before lower, stops lower before upper.
// RULE_21 - Software leaves upper pins and interrupt unused, clears its output bits.
// RULE_22 - Software does not rewrite compare while running in non-PWM modes.
// RULE_23 - Level set/clear bits: 00 keep, 01 clear, 10 set; read as 0.
// RULE_24 - Output enable low holds timer output pin low.
// RULE_25 - Clearing run clears counter to zero and holds it stopped.
// RULE_26 - Cascade: upper counter increments when lower rolls over from maximum.
`default_nettype none

module dtec_top
   import dtec_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   input wire logic lower_event_input,
   input wire logic upper_event_input,
   output logic lower_timer_output,
   output logic upper_timer_output,
   output logic lower_match_interrupt,
   output logic upper_match_interrupt
);

   // ==========================================================
   // Register state, index 0 is the lower timer, 1 the upper
   logic [2:0] count_clock_select_reg_q [2];
   dtec_mode_t timer_mode_control_reg_q [2];
   logic [7:0] compare_reg_q [2];
   logic [7:0] cmp_stage_q [2];
   logic [7:0] cmp_act_q [2];
   logic [7:0] count_value_reg_q [2];
   logic out_ff_q [2];
   logic pwm_on_q [2];
   logic irq_q [2];
   logic pin_q [2];
   logic [7:0] rdata_q;

   // ==========================================================
   // Shared decode
   logic cascade_select_bit;
   logic [15:0] cascaded_count_value;
   logic [15:0] cascaded_compare_value;
   logic match16;
   logic lower_run_bit;
   logic upper_run_bit;
   logic tick [2];
   logic event_pin [2];
   logic [7:0] rd_mux;

   assign cascade_select_bit = timer_mode_control_reg_q[1].casc; // [RULE_16]
   assign lower_run_bit = timer_mode_control_reg_q[0].run;
   assign upper_run_bit = timer_mode_control_reg_q[1].run;
   assign cascaded_count_value = {count_value_reg_q[1], count_value_reg_q[0]};
   assign cascaded_compare_value = {compare_reg_q[1], compare_reg_q[0]}; // [RULE_17]
   assign match16 = (cascaded_count_value == cascaded_compare_value); // [RULE_18]
   assign event_pin[0] = lower_event_input;
   assign event_pin[1] = upper_event_input;

   // ==========================================================
   // Per-timer count logic
   for (genvar i = 0; i < 2; i++) begin : g_tmr
      dtec_mode_t mode;
      logic run_eff;
      logic tick_eff;
      logic carry_in;
      logic [7:0] cnt;
      logic [7:0] cnt_inc;
      logic [7:0] cmp_use;
      logic match;
      logic overflow;
      logic hit;
      logic upper_in_casc;
      logic we_csel;
      logic we_mode;
      logic we_cmp;
      logic [7:0] cnt_d;
      logic pwm_on_d;
      logic ff_d;
      logic out_d;
      dtec_mode_t mode_wr;

      assign mode = timer_mode_control_reg_q[i];
      assign cnt = count_value_reg_q[i];
      assign cnt_inc = 8'(cnt + 8'h01);
      assign upper_in_casc = cascade_select_bit && (i == 1);

      dtec_tick u_tick (
         .core_clk(core_clk),
         .rst(rst),
         .sel(count_clock_select_reg_q[i]),
         .run(mode.run),
         .event_in(event_pin[i]),
         .tick(tick[i])
      );

      // In cascade both halves run from the lower clock select and event pin
      assign tick_eff = cascade_select_bit ? tick[0] : tick[i]; // [RULE_16] [RULE_19]
      // Either run bit low clears the chained count
      assign run_eff = cascade_select_bit ? (lower_run_bit && upper_run_bit)
                                          : mode.run; // [RULE_25]
      assign carry_in = upper_in_casc ? (count_value_reg_q[0] == DTEC_CNT_MAX)
                                      : 1'b1; // [RULE_26]
      // PWM compares against the buffered value, other modes use the written one
      assign cmp_use = mode.pwm ? cmp_act_q[i] : compare_reg_q[i];
      assign match = cascade_select_bit ? match16 : (cnt == cmp_use); // [RULE_03]
      assign overflow = (cnt == DTEC_CNT_MAX);
      assign hit = run_eff && tick_eff && !mode.pwm && match; // [RULE_04]

      assign cnt_d = !run_eff ? DTEC_CNT_RST : // [RULE_25]
                     !tick_eff ? cnt :
                     mode.pwm ? cnt_inc : // [RULE_07] [RULE_11]
                     match ? DTEC_CNT_RST : // [RULE_03] [RULE_18]
                     carry_in ? cnt_inc : cnt; // [RULE_02] [RULE_26]

      // Active from overflow until count reaches the compare; N = 0 gives no pulse
      assign pwm_on_d = !(run_eff && mode.pwm) ? 1'b0 : // [RULE_08] [RULE_10]
                        !tick_eff ? pwm_on_q[i] :
                        overflow ? (cmp_stage_q[i] != DTEC_CNT_RST) : // [RULE_09]
                        (cnt_inc == cmp_act_q[i]) ? 1'b0 : pwm_on_q[i]; // [RULE_09]

      // Register write decode
      assign we_csel = reg_we && (reg_addr == 3'(DTEC_ADDR_CSEL0 + 3'(i)));
      assign we_mode = reg_we && (reg_addr == 3'(DTEC_ADDR_MODE0 + 3'(i)));
      assign we_cmp = reg_we && (reg_addr == 3'(DTEC_ADDR_CMP0 + 3'(i)));
      assign mode_wr = dtec_mode_t'(reg_wdata);

      // A level write takes precedence over a match toggle in the same cycle
      assign ff_d = (we_mode && !mode_wr.pwm && mode_wr.lvl_set && !mode_wr.lvl_clr) ? 1'b1 :
                    (we_mode && !mode_wr.pwm && mode_wr.lvl_clr && !mode_wr.lvl_set) ? 1'b0 :
                    (hit && mode.inv && !upper_in_casc) ? !out_ff_q[i] :
                    out_ff_q[i]; // [RULE_23] [RULE_05]

      assign out_d = !mode.oe ? 1'b0 : // [RULE_24]
                     mode.pwm ? (pwm_on_q[i] ^ mode.inv) : out_ff_q[i]; // [RULE_07]

      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            count_clock_select_reg_q[i] <= DTEC_CSEL_RST;
            timer_mode_control_reg_q[i] <= dtec_mode_t'(DTEC_MODE_RST);
            compare_reg_q[i] <= DTEC_CMP_RST;
            count_value_reg_q[i] <= DTEC_CNT_RST;
            out_ff_q[i] <= 1'b0;
            pwm_on_q[i] <= 1'b0;
            irq_q[i] <= 1'b0;
            pin_q[i] <= 1'b0;
         end else begin
            if (we_csel) begin
               count_clock_select_reg_q[i] <= reg_wdata[2:0];
            end
            if (we_mode) begin
               timer_mode_control_reg_q[i] <= '{run: mode_wr.run, pwm: mode_wr.pwm,
                  rsvd: 1'b0, casc: (i == 1) ? mode_wr.casc : 1'b0, lvl_set: 1'b0,
                  lvl_clr: 1'b0, inv: mode_wr.inv, oe: mode_wr.oe}; // [RULE_23]
            end
            if (we_cmp) begin
               compare_reg_q[i] <= reg_wdata; // [RULE_14]
            end
            count_value_reg_q[i] <= cnt_d;
            out_ff_q[i] <= ff_d;
            pwm_on_q[i] <= pwm_on_d;
            irq_q[i] <= hit && !upper_in_casc; // [RULE_03] [RULE_18]
            pin_q[i] <= out_d;
         end
      end

      // ==========================================================
      // PWM compare buffering
      // Sampled on the count edge into FFH, applied at the overflow after it
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            cmp_stage_q[i] <= DTEC_CMP_RST;
            cmp_act_q[i] <= DTEC_CMP_RST;
         end else if (!run_eff) begin
            cmp_stage_q[i] <= compare_reg_q[i];
            cmp_act_q[i] <= compare_reg_q[i];
         end else if (tick_eff && mode.pwm) begin
            if (cnt == DTEC_CNT_PRE_MAX) begin
               cmp_stage_q[i] <= compare_reg_q[i]; // [RULE_12] [RULE_13]
            end
            if (overflow) begin
               cmp_act_q[i] <= cmp_stage_q[i]; // [RULE_12] [RULE_13]
            end
         end
      end
   end

   // ==========================================================
   // Register read path; unmapped bits read as zero
   assign rd_mux =
      (reg_addr == DTEC_ADDR_CSEL0) ? {5'h00, count_clock_select_reg_q[0]} :
      (reg_addr == DTEC_ADDR_CSEL1) ? {5'h00, count_clock_select_reg_q[1]} :
      (reg_addr == DTEC_ADDR_MODE0) ? 8'(timer_mode_control_reg_q[0]) :
      (reg_addr == DTEC_ADDR_MODE1) ? 8'(timer_mode_control_reg_q[1]) :
      (reg_addr == DTEC_ADDR_CMP0) ? compare_reg_q[0] : // [RULE_14]
      (reg_addr == DTEC_ADDR_CMP1) ? compare_reg_q[1] :
      (reg_addr == DTEC_ADDR_CNT0) ? count_value_reg_q[0] : count_value_reg_q[1];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_re ? rd_mux : 8'h00;
      end
   end

   // ==========================================================
   // Outputs, all from flip-flops
   assign reg_rdata = rdata_q;
   assign lower_timer_output = pin_q[0];
   assign upper_timer_output = pin_q[1];
   assign lower_match_interrupt = irq_q[0];
   assign upper_match_interrupt = irq_q[1];

endmodule : dtec_top

`default_nettype wire

// ===== inc/dtec_pkg.sv
// Shared constants and types for the dual 8-bit timer/event counter
`default_nettype none

package dtec_pkg;

   // ==========================================================
   // Register map (byte-wide registers, 3-bit index)
   localparam logic [2:0] DTEC_ADDR_CSEL0 = 3'h0;
   localparam logic [2:0] DTEC_ADDR_CSEL1 = 3'h1;
   localparam logic [2:0] DTEC_ADDR_MODE0 = 3'h2;
   localparam logic [2:0] DTEC_ADDR_MODE1 = 3'h3;
   localparam logic [2:0] DTEC_ADDR_CMP0 = 3'h4;
   localparam logic [2:0] DTEC_ADDR_CMP1 = 3'h5;
   localparam logic [2:0] DTEC_ADDR_CNT0 = 3'h6;
   localparam logic [2:0] DTEC_ADDR_CNT1 = 3'h7;

   // ==========================================================
   // Reset values and count limits
   localparam logic [2:0] DTEC_CSEL_RST = 3'h0;
   localparam logic [7:0] DTEC_MODE_RST = 8'h00;
   localparam logic [7:0] DTEC_CMP_RST = 8'h00;
   localparam logic [7:0] DTEC_CNT_RST = 8'h00;
   localparam logic [7:0] DTEC_CNT_MAX = 8'hFF;
   localparam logic [7:0] DTEC_CNT_PRE_MAX = 8'hFE;

   // ==========================================================
   // Count clock selection codes
   localparam logic [2:0] DTEC_CSEL_FALL = 3'h0;
   localparam logic [2:0] DTEC_CSEL_RISE = 3'h1;
   localparam logic [2:0] DTEC_CSEL_DIV4 = 3'h2;
   localparam logic [2:0] DTEC_CSEL_DIV8 = 3'h3;
   localparam logic [2:0] DTEC_CSEL_DIV16 = 3'h4;
   localparam logic [2:0] DTEC_CSEL_DIV32 = 3'h5;
   localparam logic [2:0] DTEC_CSEL_DIV128 = 3'h6;
   localparam logic [2:0] DTEC_CSEL_DIV512 = 3'h7;

   // Prescaler terminal masks (divide ratio minus one)
   localparam logic [8:0] DTEC_MASK_DIV4 = 9'h003;
   localparam logic [8:0] DTEC_MASK_DIV8 = 9'h007;
   localparam logic [8:0] DTEC_MASK_DIV16 = 9'h00F;
   localparam logic [8:0] DTEC_MASK_DIV32 = 9'h01F;
   localparam logic [8:0] DTEC_MASK_DIV128 = 9'h07F;
   localparam logic [8:0] DTEC_MASK_DIV512 = 9'h1FF;

   // ==========================================================
   // Mode control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic run;
      logic pwm;
      logic rsvd;
      logic casc;
      logic lvl_set;
      logic lvl_clr;
      logic inv;
      logic oe;
   } dtec_mode_t;

endpackage : dtec_pkg

`default_nettype wire

// ===== test/dtec_chk.sv
// Port-level checker for the dual timer/event counter
`default_nettype none
module dtec_chk
   import dtec_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [7:0] reg_rdata,
   input wire logic lower_timer_output,
   input wire logic lower_match_interrupt,
   input wire logic upper_match_interrupt
);
   // ==========================================================
   // Shadows of software writes
   dtec_mode_t m0_q;
   dtec_mode_t m1_q;
   logic [7:0] cmp0_q;
   logic [1:0] age_q;
   wire logic wr_m0 = reg_we && reg_addr == DTEC_ADDR_MODE0;
   wire logic steady = age_q == 2'h3;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         m0_q <= '0;
         m1_q <= '0;
         cmp0_q <= '0;
         age_q <= '0;
      end else begin
         if (wr_m0) m0_q <= reg_wdata;
         if (reg_we && reg_addr == DTEC_ADDR_MODE1) m1_q <= reg_wdata;
         if (reg_we && reg_addr == DTEC_ADDR_CMP0) cmp0_q <= reg_wdata;
         // Saturates; the output pin lags a mode write by two edges, three when the write stops PWM
         age_q <= wr_m0 ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
      end
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence rd_of(logic [2:0] a);
      reg_re && reg_addr == a;
   endsequence
   level_read_a: assert property (
      rd_of(DTEC_ADDR_MODE0) |=> reg_rdata[3:2] == 2'b00) else $error("level bits read set");
   cmp_read_a: assert property (
      rd_of(DTEC_ADDR_CMP0) |=> reg_rdata == $past(cmp0_q)) else $error("compare readback");
   cnt_stop_a: assert property (
      rd_of(DTEC_ADDR_CNT0) ##0 (!m0_q.run && !$past(m0_q.run)) |=> reg_rdata == 8'h00)
      else $error("stopped count not zero");
   oe_low_a: assert property (
      steady && !m0_q.oe |-> !lower_timer_output) else $error("disabled output not low");
   pwm_idle_a: assert property (
      steady && m0_q.pwm && !m0_q.run && m0_q.oe |-> lower_timer_output == m0_q.inv)
      else $error("stopped pwm output not inactive");
   level_set_a: assert property (
      wr_m0 && reg_wdata[7:6] == 2'b00 && reg_wdata[3:2] == 2'b10 && reg_wdata[0]
      |-> ##[1:3] lower_timer_output) else $error("level set did not drive high");
   irq_pulse_a: assert property (
      $rose(lower_match_interrupt) |=> !lower_match_interrupt) else $error("interrupt too long");
   casc_upper_a: assert property (
      m1_q.casc && $past(m1_q.casc) |-> !upper_match_interrupt) else $error("upper irq in cascade");
endmodule : dtec_chk

bind dtec_top dtec_chk dtec_chk_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
   .lower_timer_output(lower_timer_output), .lower_match_interrupt(lower_match_interrupt),
   .upper_match_interrupt(upper_match_interrupt));
`default_nettype wire

// ===== test/dtec_evsrc.sv
// External event source: clean pulses of four cycles high, four low
`default_nettype none
module dtec_evsrc (
   input wire logic core_clk,
   input wire logic go,
   input wire logic [15:0] n_pulses,
   output logic pin,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] left_q;
   logic [2:0] ph_q;
   initial begin
      pin = 1'b0;
      busy = 1'b0;
   end
   always @(posedge core_clk) begin
      if (go && !busy) begin
         left_q <= n_pulses;
         busy <= n_pulses != 16'h0000;
         ph_q <= 3'h0;
      end else if (busy) begin
         ph_q <= ph_q + 3'h1;
         if (ph_q == 3'h3) pin <= 1'b1;
         if (ph_q == 3'h7) begin
            pin <= 1'b0;
            left_q <= left_q - 16'h0001;
            busy <= left_q != 16'h0001;
         end
      end
   end
endmodule : dtec_evsrc
`default_nettype wire

// ===== test/tb_dtec_top.sv
// Register-driven testbench for the dual timer/event counter
`default_nettype none
module tb_dtec_top
   import dtec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst, reg_we, reg_re, lo_go, hi_go, lo_busy, hi_busy;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [15:0] ev_n;
   logic lower_event_input, upper_event_input, lower_timer_output, upper_timer_output;
   logic lower_match_interrupt, upper_match_interrupt;
   int n_mismatch = 0, checked = 0, cyc = 0, irq_lo = 0, irq_hi = 0, b0, b1, t0, t1, t2, t3;
   dtec_top dtec_top_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .lower_event_input(lower_event_input), .upper_event_input(upper_event_input),
      .lower_timer_output(lower_timer_output), .upper_timer_output(upper_timer_output),
      .lower_match_interrupt(lower_match_interrupt),
      .upper_match_interrupt(upper_match_interrupt));
   dtec_evsrc lo_src_i (.core_clk(core_clk), .go(lo_go), .n_pulses(ev_n),
      .pin(lower_event_input), .busy(lo_busy));
   dtec_evsrc hi_src_i (.core_clk(core_clk), .go(hi_go), .n_pulses(ev_n),
      .pin(upper_event_input), .busy(hi_busy));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (lower_match_interrupt === 1'b1) irq_lo <= irq_lo + 1;
      if (upper_match_interrupt === 1'b1) irq_hi <= irq_hi + 1;
   end
   // ==========================================================
   // Tasks
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_we <= 1'b1;
      @(posedge core_clk);
      reg_we <= 1'b0;
   endtask : wr
   task automatic chk(input logic [2:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge core_clk);
      reg_re <= 1'b0;
      #1;
      cmp("reg", {8'h00, v}, {8'h00, reg_rdata});
   endtask : chk
   // Bounded wait; a missing pulse shows up in the counts afterwards
   task automatic ev(input logic hi, input logic [15:0] n);
      @(posedge core_clk);
      ev_n <= n;
      if (hi) hi_go <= 1'b1;
      else lo_go <= 1'b1;
      @(posedge core_clk);
      hi_go <= 1'b0;
      lo_go <= 1'b0;
      // Busy rises on the edge that takes go, so let one more edge pass before polling
      @(posedge core_clk);
      for (int i = 0; i < 3000 && (hi ? hi_busy : lo_busy); i++) @(posedge core_clk);
      repeat (4) @(posedge core_clk);
   endtask : ev
   task automatic out_to(input logic lvl, output int t);
      for (int i = 0; i < 3000; i++) begin
         @(posedge core_clk);
         #1;
         if (lower_timer_output === lvl) break;
      end
      t = cyc;
   endtask : out_to
   task automatic pin_is(input logic v);
      repeat (3) @(posedge core_clk);
      #1;
      cmp("pin", {15'h0000, v}, {15'h0000, lower_timer_output});
   endtask : pin_is
   task automatic wrap_up;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #(25 * 30000);
      n_mismatch++;
      wrap_up;
   end
   // ==========================================================
   // Tests
   initial begin
      {rst, reg_we, reg_re, lo_go, hi_go, reg_addr, reg_wdata, ev_n} = {1'b1, 31'h0};
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) chk(a[2:0], 8'h00);
      wr(DTEC_ADDR_CNT0, 8'h55);
      chk(DTEC_ADDR_CNT0, 8'h00);
      wr(DTEC_ADDR_MODE0, 8'h0C);
      chk(DTEC_ADDR_MODE0, 8'h00);
      for (int s = 0; s < 2; s++) begin
         wr(DTEC_ADDR_CSEL0, s[2:0]);
         wr(DTEC_ADDR_CMP0, 8'h02);
         wr(DTEC_ADDR_MODE0, 8'h80);
         b0 = irq_lo;
         ev(1'b0, 16'd3);
         cmp("irq", 16'(irq_lo - b0), 16'd1);
         chk(DTEC_ADDR_CNT0, 8'h00);
         ev(1'b0, 16'd2);
         chk(DTEC_ADDR_CNT0, 8'h02);
         wr(DTEC_ADDR_MODE0, 8'h00);
         chk(DTEC_ADDR_CNT0, 8'h00);
      end
      wr(DTEC_ADDR_CSEL0, DTEC_CSEL_DIV4);
      wr(DTEC_ADDR_CMP0, 8'h01);
      wr(DTEC_ADDR_MODE0, 8'h07);
      pin_is(1'b0);
      wr(DTEC_ADDR_MODE0, 8'h0B);
      pin_is(1'b1);
      wr(DTEC_ADDR_MODE0, 8'h8B);
      out_to(1'b0, t0);
      out_to(1'b1, t1);
      out_to(1'b0, t2);
      cmp("half", 16'(t1 - t0), 16'd8);
      cmp("half", 16'(t2 - t1), 16'd8);
      wr(DTEC_ADDR_MODE0, 8'h00);
      pin_is(1'b0);
      wr(DTEC_ADDR_CMP0, 8'h40);
      wr(DTEC_ADDR_MODE0, 8'h41);
      wr(DTEC_ADDR_MODE0, 8'hC1);
      t0 = cyc;
      out_to(1'b1, t1);
      cmp("first", 16'(t1 - t0 > 1020), 16'd1);
      out_to(1'b0, t2);
      cmp("width", 16'(t2 - t1), 16'd256);
      out_to(1'b1, t3);
      cmp("period", 16'(t3 - t1), 16'd1024);
      wr(DTEC_ADDR_CMP0, 8'h20);
      chk(DTEC_ADDR_CMP0, 8'h20);
      out_to(1'b0, t2);
      cmp("old", 16'(t2 - t3), 16'd256);
      out_to(1'b1, t1);
      out_to(1'b0, t2);
      cmp("new", 16'(t2 - t1), 16'd128);
      out_to(1'b1, t1);
      wr(DTEC_ADDR_MODE0, 8'h41);
      pin_is(1'b0);
      wr(DTEC_ADDR_MODE0, 8'h43);
      pin_is(1'b1);
      wr(DTEC_ADDR_MODE0, 8'h00);
      wr(DTEC_ADDR_CSEL0, DTEC_CSEL_RISE);
      wr(DTEC_ADDR_CMP0, 8'h00);
      wr(DTEC_ADDR_CMP1, 8'h01);
      wr(DTEC_ADDR_MODE1, 8'h90);
      wr(DTEC_ADDR_MODE0, 8'h80);
      b0 = irq_lo;
      b1 = irq_hi;
      ev(1'b0, 16'd256);
      chk(DTEC_ADDR_CNT0, 8'h00);
      chk(DTEC_ADDR_CNT1, 8'h01);
      ev(1'b1, 16'd4);
      chk(DTEC_ADDR_CNT1, 8'h01);
      cmp("irq", 16'(irq_lo - b0), 16'd0);
      ev(1'b0, 16'd1);
      cmp("irq", 16'(irq_lo - b0), 16'd1);
      cmp("upper", 16'(irq_hi - b1), 16'd0);
      cmp("upper pin", 16'h0000, {15'h0000, upper_timer_output});
      chk(DTEC_ADDR_CNT1, 8'h00);
      wr(DTEC_ADDR_MODE0, 8'h00);
      wr(DTEC_ADDR_MODE1, 8'h00);
      wrap_up;
   end
endmodule : tb_dtec_top
`default_nettype wire
